// *** rtl/cah_pkg.sv ***
// cah_pkg: constants and carriers for the configuration and harmonic limit command block.
// assumes commands arrive already parsed into fields by an upstream text parser.
package cah_pkg;
    localparam int         CHAN_NUM   = 4;      // installed channels
    localparam int         GRP_NUM    = 3;      // analyzer groups
    localparam int         HARM_MAX   = 500;    // harmonics 1..500
    localparam int         PCT_SCALE  = 10000;  // plimit lsb is 0.01 %
    localparam logic [1:0] SEL_V      = 2'h0;
    localparam logic [1:0] SEL_A      = 2'h1;
    localparam logic [1:0] LT_NONE    = 2'h0;
    localparam logic [1:0] LT_MAX     = 2'h1;
    localparam logic [1:0] LT_SUM     = 2'h2;
    localparam logic [1:0] GRP_NONE   = 2'h0;
    localparam logic [1:0] GRP_LAST   = 2'h3;
    localparam logic [2:0] WIRING_MAX = 3'h4;
    localparam logic [2:0] WIRING_RST = 3'h0;
    localparam logic [8:0] HARM_LAST  = 9'h1f3;

    typedef enum logic [3:0] {
        OP_GRP_Q, OP_WIRING_Q, OP_GRP_SET, OP_WIRING_SET, OP_TSAVE, OP_TRESTORE,
        OP_HCLR, OP_HSET, OP_HQUERY, OP_HCOMMIT
    } cah_op_t;

    typedef struct packed {
        logic [1:0]        ltype;
        logic              pbase;   // 0 fundamental, 1 total
        logic signed [15:0] plimit;
        logic signed [15:0] llimit;
    } cah_lim_t;

    typedef struct packed {
        cah_op_t    op;
        logic [1:0] sel;
        logic [2:0] chan;
        logic [1:0] grp;
        logic [2:0] wiring;
        logic [8:0] harm;
        cah_lim_t   lim;
    } cah_cmd_t;

    typedef struct packed {
        logic       err;
        logic [2:0] value;
        logic [1:0] sel;
        logic [8:0] harm;
        cah_lim_t   lim;
    } cah_rsp_t;

    typedef struct packed {
        logic [CHAN_NUM-1:0][1:0] chan_grp;
        logic [GRP_NUM-1:0][2:0]  wiring;
    } cah_cfg_t;
endpackage : cah_pkg

// *** rtl/cah_cmd_ctrl.sv ***
// cah_cmd_ctrl: group/wiring queries, temporary config save/restore, harmonic limits.
// assumes parsed commands on the core_clk domain and a persistent store taking a word per cycle.
// Summary of operation
// - group query returns channel's group 1..3, or 0 if unassigned or absent.
// - wiring query returns group's wiring code 0..4.
// - temp save copies the whole live configuration into temporary storage.
// - temporary copy lives in plain flops only, lost at power off.
// - temp restore reloads last saved copy, error if none saved.
// - only one restore per save; a second restore errors.
// - limit changes act on evaluation at once; persistent only after commit.
// - limit type 0..2; type 0 means no limit, other fields ignored.
// - type 1 effective limit is the larger of percentage and level limit.
// - type 2 effective limit is percentage limit plus level limit.
// - percentage base 0 is fundamental, 1 is total signal.
// - percentage and level limits must be zero or greater.
// - a type 1 or 2 limit with both values zero always fails; type 0 never fails.
// - limit query returns all fields needed to recreate the set command.
`timescale 1ns/1ps
module cah_cmd_ctrl
    import cah_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic            cmd_valid,
    input  wire cah_pkg::cah_cmd_t cmd,
    output logic                 cmd_ready,
    output logic                 rsp_valid,
    output cah_pkg::cah_rsp_t    rsp,
    input  wire logic            eval_sel,
    input  wire logic [8:0]      eval_harm,
    input  wire logic [15:0]     eval_fund,
    input  wire logic [15:0]     eval_total,
    input  wire logic [15:0]     eval_meas,
    output logic                 eval_fail,
    output logic                 nv_wr_valid,
    output logic                 nv_wr_sel,
    output logic [8:0]           nv_wr_addr,
    output cah_pkg::cah_lim_t    nv_wr_data
);
    import cah_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_COMMIT} cah_state_t;

    function automatic logic harm_ok(input logic [8:0] h);
        harm_ok = (h != 9'h000) && (h <= 9'(HARM_MAX));   // 1..500 inclusive
    endfunction : harm_ok

    function automatic logic cmd_ok(input cah_cmd_t c);
        logic sel_ok;
        sel_ok = (c.sel == SEL_V) || (c.sel == SEL_A);
        case (c.op)
            OP_GRP_Q, OP_GRP_SET: cmd_ok = (c.chan != 3'h0);
            OP_WIRING_Q:   cmd_ok = (c.grp != GRP_NONE);
            OP_WIRING_SET: cmd_ok = (c.grp != GRP_NONE) && (c.wiring <= WIRING_MAX);
            OP_HCLR, OP_HCOMMIT: cmd_ok = sel_ok;
            OP_HQUERY:     cmd_ok = sel_ok && harm_ok(c.harm);
            OP_HSET:       cmd_ok = sel_ok && harm_ok(c.harm) && (c.lim.ltype <= LT_SUM)
                                    && ((c.lim.ltype == LT_NONE) || (!c.lim.plimit[15]
                                    && !c.lim.llimit[15]));
            default:       cmd_ok = 1'b1;
        endcase
    endfunction : cmd_ok

    cah_state_t state_reg, state_next;
    cah_cfg_t   cfg_reg, cfg_next, tmp_reg, tmp_next;   // plain flops, lost at power off
    logic       tmp_valid_reg, tmp_valid_next;
    logic [1:0] rows_reg, rows_next;
    logic [8:0] idx_reg, idx_next;
    logic       pend_reg, pend_next;
    logic       rsp_valid_next;
    cah_rsp_t   rsp_reg, rsp_next;
    logic       nv_valid_next;
    logic [8:0] nv_addr_next;
    cah_lim_t   nv_data_next;
    logic       nv_sel_next;
    logic [1:0] mem_we;
    logic [8:0] mem_idx;
    cah_lim_t   mem_wdata;
    logic       fire;
    logic [1:0] ch_idx, gr_idx;
    cah_lim_t   lim_mem [2][HARM_MAX];   // no reset: the walk after reset clears it

    assign cmd_ready = (state_reg == ST_IDLE);
    assign fire      = cmd_valid && cmd_ready;
    assign ch_idx    = 2'(cmd.chan - 3'h1);
    assign gr_idx    = cmd.grp - 2'h1;

    always_comb begin
        state_next     = state_reg;
        cfg_next       = cfg_reg;
        tmp_next       = tmp_reg;
        tmp_valid_next = tmp_valid_reg;
        rows_next      = rows_reg;
        idx_next       = idx_reg;
        pend_next      = pend_reg;
        rsp_valid_next = 1'b0;
        rsp_next       = rsp_reg;
        nv_valid_next  = 1'b0;
        nv_sel_next    = rows_reg[1];
        nv_addr_next   = idx_reg;
        nv_data_next   = '0;
        mem_we         = 2'b00;
        mem_idx        = idx_reg;
        mem_wdata      = '0;
        case (state_reg)
            ST_IDLE: begin
                if (fire) begin
                    rsp_next      = '0;
                    rsp_next.sel  = cmd.sel;
                    rsp_next.harm = cmd.harm;
                    rsp_valid_next = 1'b1;
                    if (!cmd_ok(cmd)) begin
                        rsp_next.err = 1'b1;   // nothing stored changes
                    end else begin
                        case (cmd.op)
                            OP_GRP_Q: begin
                                // absent channels read as no group
                                if (cmd.chan <= 3'(CHAN_NUM)) begin
                                    rsp_next.value = {1'b0, cfg_reg.chan_grp[ch_idx]};
                                end
                            end
                            OP_WIRING_Q: rsp_next.value = cfg_reg.wiring[gr_idx];
                            OP_GRP_SET: begin
                                if (cmd.chan <= 3'(CHAN_NUM)) begin
                                    cfg_next.chan_grp[ch_idx] = cmd.grp;
                                end else begin
                                    rsp_next.err = 1'b1;
                                end
                            end
                            OP_WIRING_SET: cfg_next.wiring[gr_idx] = cmd.wiring;
                            OP_TSAVE: begin
                                tmp_next       = cfg_reg;
                                tmp_valid_next = 1'b1;
                            end
                            OP_TRESTORE: begin
                                if (tmp_valid_reg) begin
                                    cfg_next       = tmp_reg;
                                    tmp_valid_next = 1'b0;
                                end else begin
                                    rsp_next.err = 1'b1;
                                end
                            end
                            OP_HCLR, OP_HCOMMIT: begin
                                rsp_valid_next = 1'b0;
                                pend_next      = 1'b1;
                                idx_next       = 9'h000;
                                rows_next      = cmd.sel[0] ? 2'b10 : 2'b01;
                                state_next     = (cmd.op == OP_HCLR) ? ST_CLEAR : ST_COMMIT;
                            end
                            OP_HSET: begin
                                // live table write, seen by evaluation next cycle
                                mem_we[cmd.sel[0]] = 1'b1;
                                mem_idx = cmd.harm - 9'h001;
                                if (cmd.lim.ltype != LT_NONE) begin
                                    mem_wdata = cmd.lim;   // type 0 stores zeros
                                end
                            end
                            OP_HQUERY: rsp_next.lim = lim_mem[cmd.sel[0]][cmd.harm - 9'h001];
                            default: rsp_next.err = 1'b1;
                        endcase
                    end
                end
            end
            ST_CLEAR, ST_COMMIT: begin
                if (state_reg == ST_CLEAR) begin
                    mem_we = rows_reg;
                end else begin
                    nv_valid_next = 1'b1;
                    nv_data_next  = lim_mem[rows_reg[1]][idx_reg];
                end
                idx_next = idx_reg + 9'h001;
                if (idx_reg == HARM_LAST) begin
                    state_next     = ST_IDLE;
                    rsp_valid_next = pend_reg;
                    pend_next      = 1'b0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg     <= ST_CLEAR;   // wipe both tables after reset
            rows_reg      <= 2'b11;
            idx_reg       <= 9'h000;
            pend_reg      <= 1'b0;
            cfg_reg       <= '0;
            tmp_reg       <= '0;
            tmp_valid_reg <= 1'b0;
            rsp_valid     <= 1'b0;
            rsp_reg       <= '0;
            nv_wr_valid   <= 1'b0;
            nv_wr_sel     <= 1'b0;
            nv_wr_addr    <= 9'h000;
            nv_wr_data    <= '0;
        end else begin
            state_reg     <= state_next;
            rows_reg      <= rows_next;
            idx_reg       <= idx_next;
            pend_reg      <= pend_next;
            cfg_reg       <= cfg_next;
            tmp_reg       <= tmp_next;
            tmp_valid_reg <= tmp_valid_next;
            rsp_valid     <= rsp_valid_next;
            rsp_reg       <= rsp_next;
            nv_wr_valid   <= nv_valid_next;
            nv_wr_sel     <= nv_sel_next;
            nv_wr_addr    <= nv_addr_next;
            nv_wr_data    <= nv_data_next;
        end
    end
    assign rsp = rsp_reg;

    // one process writes both rows: a variable index from two processes is a double driver
    always_ff @(posedge core_clk) begin
        for (int r = 0; r < 2; r++) begin
            if (mem_we[r]) begin
                lim_mem[r][mem_idx] <= mem_wdata;
            end
        end
    end

    // evaluation path, reads the live table so edits apply at once
    cah_lim_t    ev_lim;
    logic [31:0] ev_pct, ev_eff;
    logic        ev_fail_next, eval_fail_reg;

    always_comb begin
        ev_lim = harm_ok(eval_harm) ? lim_mem[eval_sel][eval_harm - 9'h001] : '0;
        ev_pct = ({16'h0000, ev_lim.pbase ? eval_total : eval_fund}
                  * {16'h0000, 16'(ev_lim.plimit)}) / 32'(PCT_SCALE);
        if (ev_lim.ltype == LT_SUM) begin
            ev_eff = ev_pct + {16'h0000, 16'(ev_lim.llimit)};
        end else begin
            // the larger of the two governs, so a loose limit masks a tight one
            ev_eff = (ev_pct > {16'h0000, 16'(ev_lim.llimit)}) ? ev_pct
                     : {16'h0000, 16'(ev_lim.llimit)};
        end
        ev_fail_next = (ev_lim.ltype != LT_NONE)
                       && ((ev_lim.plimit == 16'sh0000 && ev_lim.llimit == 16'sh0000)
                           || ({16'h0000, eval_meas} > ev_eff));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            eval_fail_reg <= 1'b0;
        end else begin
            eval_fail_reg <= ev_fail_next;
        end
    end
    assign eval_fail = eval_fail_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_absent_chan_zero: assert property (fire && cmd.op == OP_GRP_Q && cmd.chan > 3'h4
        |=> rsp_valid && !rsp.err && rsp.value == 3'h0) else $error("absent channel not 0");
    a_wiring_code: assert property (fire && cmd.op == OP_WIRING_Q && cmd_ok(cmd)
        |=> rsp_valid && rsp.value <= 3'h4) else $error("wiring code out of range");
    a_save_copies: assert property (fire && cmd.op == OP_TSAVE
        |=> tmp_valid_reg && tmp_reg == $past(cfg_reg)) else $error("save did not copy");
    a_restore_nosave: assert property (fire && cmd.op == OP_TRESTORE && !tmp_valid_reg
        |=> rsp.err && cfg_reg == $past(cfg_reg)) else $error("restore without save");
    a_restore_once: assert property (fire && cmd.op == OP_TRESTORE
        |=> !tmp_valid_reg ##1 !tmp_valid_reg || $past(fire && cmd.op == OP_TSAVE))
        else $error("second restore allowed");
    a_clear_done: assert property (fire && cmd.op == OP_HCLR && cmd_ok(cmd)
        |-> ##[501:501] rsp_valid && !rsp.err) else $error("clear walk length wrong");
    a_commit_stream: assert property (fire && cmd.op == OP_HCOMMIT && cmd_ok(cmd)
        |=> ##1 nv_wr_valid [*8]) else $error("commit not streaming");
    a_bad_rejected: assert property (fire && !cmd_ok(cmd)
        |=> rsp_valid && rsp.err && cfg_reg == $past(cfg_reg)) else $error("bad cmd accepted");
    a_zero_fails: assert property (ev_lim.ltype != LT_NONE && ev_lim.plimit == 16'sh0000
        && ev_lim.llimit == 16'sh0000 |=> eval_fail) else $error("zero limit passed");
    a_none_passes: assert property (ev_lim.ltype == LT_NONE |=> !eval_fail)
        else $error("type 0 failed");

    c_restore_ok: cover property (fire && cmd.op == OP_TRESTORE && tmp_valid_reg);
    c_commit_end: cover property (nv_wr_valid && nv_wr_addr == HARM_LAST);
    c_eval_fail:  cover property (eval_fail && ev_lim.ltype == LT_SUM);
endmodule : cah_cmd_ctrl

// *** tb/cah_nv_model.sv ***
// cah_nv_model: persistent limit store sitting on the commit port.
// assumes one limit word per core_clk cycle while nv_wr_valid is high.
`timescale 1ns/1ps
module cah_nv_model
    import cah_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              nv_wr_valid,
    input wire logic              nv_wr_sel,
    input wire logic [8:0]        nv_wr_addr,
    input wire cah_pkg::cah_lim_t nv_wr_data
);
    cah_lim_t mem [0:1][0:511];
    int       wr_count = 0;
    // no backpressure: the store must keep up with one word a cycle
    always @(posedge core_clk) begin
        if (nv_wr_valid === 1'b1) begin
            mem[nv_wr_sel][nv_wr_addr] <= nv_wr_data;
            wr_count                   <= wr_count + 1;
        end
    end
endmodule : cah_nv_model

// *** tb/test_config_and_harmonic_limit_commands.sv ***
// test_config_and_harmonic_limit_commands: command-level bench for cah_cmd_ctrl.
// assumes inputs change 1 ns after each rising edge; nv model catches commit words.
`timescale 1ns/1ps
module test_config_and_harmonic_limit_commands;
    import cah_pkg::*;
    logic        core_clk, rst, cmd_valid, cmd_ready, rsp_valid, eval_sel, eval_fail;
    logic        nv_wr_valid, nv_wr_sel;
    logic [8:0]  eval_harm, nv_wr_addr;
    logic [15:0] eval_fund, eval_total, eval_meas;
    cah_cmd_t    cmd;
    cah_rsp_t    rsp, r;
    cah_lim_t    nv_wr_data, lz, la;
    cah_lim_t    tl [0:4];
    logic [15:0] tm [0:4];
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    cah_cmd_ctrl u_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp), .eval_sel(eval_sel),
        .eval_harm(eval_harm), .eval_fund(eval_fund), .eval_total(eval_total),
        .eval_meas(eval_meas), .eval_fail(eval_fail), .nv_wr_valid(nv_wr_valid),
        .nv_wr_sel(nv_wr_sel), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data));
    cah_nv_model u_nv (.core_clk(core_clk), .nv_wr_valid(nv_wr_valid), .nv_wr_sel(nv_wr_sel),
        .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // two clearing walks, one commit walk plus short commands fit well inside this
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // holds the command until taken, then waits a bounded time for the answer
    task automatic run(input cah_op_t op, input logic [1:0] sel, input logic [2:0] chan,
                       input logic [1:0] grp, input logic [2:0] w, input logic [8:0] h,
                       input cah_lim_t l);
        int n;
        n         = 0;
        cmd       = '{op:op, sel:sel, chan:chan, grp:grp, wiring:w, harm:h, lim:l};
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 1600) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 1600) begin
            bad_count++;
            $display("BAD answer wait expected rsp_valid seen none");
        end
        r = rsp;
        // one idle edge so the next call never re-raises cmd_valid in this step
        @(posedge core_clk);
        #1;
    endtask : run

    task automatic ev(input logic [15:0] meas, input logic exp);
        eval_meas = meas;
        @(posedge core_clk);
        #1;
        check("eval_fail", eval_fail, exp);
    endtask : ev

    initial begin
        rst = 1'b1; cmd_valid = 1'b0; cmd = '0; eval_sel = 1'b0; eval_harm = 9'h1f4;
        eval_fund = 16'h03e8; eval_total = 16'h07d0; eval_meas = 16'h0000;
        lz = '0;
        la = '{ltype:LT_MAX, pbase:1'b0, plimit:16'sh03e8, llimit:16'sh0032};
        tl[0] = la;
        tl[1] = '{ltype:LT_MAX, pbase:1'b1, plimit:16'sh03e8, llimit:16'sh0032};
        tl[2] = '{ltype:LT_SUM, pbase:1'b0, plimit:16'sh03e8, llimit:16'sh0032};
        tl[3] = '{ltype:LT_NONE, pbase:1'b1, plimit:16'sh0001, llimit:16'sh0001};
        tm[0] = 16'h0064; tm[1] = 16'h00c8; tm[2] = 16'h0096; tm[3] = 16'h7ffe;
        // level above percentage: the larger one must win
        tl[4] = '{ltype:LT_MAX, pbase:1'b0, plimit:16'sh0064, llimit:16'sh0078};
        tm[4] = 16'h0078;
        repeat (3) @(posedge core_clk);
        #1;
        rst = 1'b0;
        run(OP_TRESTORE, SEL_V, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        check("restore_no_save", r.err, 1'b1);
        run(OP_GRP_SET, SEL_V, 3'h1, 2'h2, 3'h0, 9'h0, lz);
        run(OP_GRP_Q, SEL_V, 3'h1, 2'h0, 3'h0, 9'h0, lz);
        check("grp_member", r.value, 3'h2);
        run(OP_GRP_Q, SEL_V, 3'h6, 2'h0, 3'h0, 9'h0, lz);
        check("grp_absent", r.value, 3'h0);
        for (int w = 0; w < 6; w++) begin
            run(OP_WIRING_SET, SEL_V, 3'h0, 2'h1, 3'(w), 9'h0, lz);
            check("wiring_set_err", r.err, w == 5);
            run(OP_WIRING_Q, SEL_V, 3'h0, 2'h1, 3'h0, 9'h0, lz);
            check("wiring_code", r.value, (w == 5) ? 3'h4 : 3'(w));
        end
        run(OP_TSAVE, SEL_V, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        run(OP_GRP_SET, SEL_V, 3'h1, 2'h3, 3'h0, 9'h0, lz);
        run(OP_WIRING_SET, SEL_V, 3'h0, 2'h1, 3'h0, 9'h0, lz);
        run(OP_TRESTORE, SEL_V, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        check("restore_ok", r.err, 1'b0);
        run(OP_GRP_Q, SEL_V, 3'h1, 2'h0, 3'h0, 9'h0, lz);
        check("restored_grp", r.value, 3'h2);
        run(OP_WIRING_Q, SEL_V, 3'h0, 2'h1, 3'h0, 9'h0, lz);
        check("restored_wiring", r.value, 3'h4);
        run(OP_TRESTORE, SEL_V, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        check("restore_twice", r.err, 1'b1);
        // each type 1 or 2 limit passes exactly at its effective value and fails one above; type 0 passes both
        for (int k = 0; k < 5; k++) begin
            run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, tl[k]);
            ev(tm[k], 1'b0);
            ev(tm[k] + 16'h0001, k != 3);
        end
        run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, la);
        run(OP_HQUERY, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, lz);
        check("hquery_lim", r.lim, la);
        check("hquery_harm", r.harm, 9'h1f4);
        check("hquery_sel", r.sel, SEL_V);
        run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, '{LT_MAX, 1'b0, 16'sh0, 16'sh0});
        ev(16'h0000, 1'b1);
        run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h0, la);
        check("harm_zero_err", r.err, 1'b1);
        run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, '{2'h3, 1'b0, 16'sh1, 16'sh1});
        check("ltype_err", r.err, 1'b1);
        run(OP_HSET, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, '{LT_MAX, 1'b0, -16'sh1, 16'sh1});
        check("neg_err", r.err, 1'b1);
        run(OP_HQUERY, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, lz);
        check("unchanged", r.lim, 35'(cah_lim_t'{LT_MAX, 1'b0, 16'sh0, 16'sh0}));
        run(OP_HSET, SEL_A, 3'h0, 2'h0, 3'h0, 9'h001, la);
        check("nv_before_commit", 48'(u_nv.wr_count), 48'd0);
        run(OP_HCOMMIT, SEL_A, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        run(OP_HCLR, SEL_A, 3'h0, 2'h0, 3'h0, 9'h0, lz);
        check("nv_words", 48'(u_nv.wr_count), 48'd500);
        check("nv_word0", u_nv.mem[1][0], la);
        run(OP_HQUERY, SEL_A, 3'h0, 2'h0, 3'h0, 9'h001, lz);
        check("cleared", r.lim, lz);
        run(OP_HQUERY, SEL_V, 3'h0, 2'h0, 3'h0, 9'h1f4, lz);
        check("other_row_kept", r.lim, 35'(cah_lim_t'{LT_MAX, 1'b0, 16'sh0, 16'sh0}));
        report_and_stop();
    end
endmodule : test_config_and_harmonic_limit_commands
